// *** verilog/i2cbs_params.svh ***
// offsets, field positions, reset values and timing of the i2c byte sequencer
`ifndef I2CBS_PARAMS_SVH
`define I2CBS_PARAMS_SVH

// system clock rate and conversion of a least time to whole cycles
`define I2CBS_CLK_MHZ        100
`define I2CBS_NS2CYC(ns)     ((((ns) * `I2CBS_CLK_MHZ) + 999) / 1000)

// bus timing in ns, standard and fast mode
`define I2CBS_T_HOLD_STD_NS  4000
`define I2CBS_T_HOLD_FST_NS  600
`define I2CBS_T_SETUP_STD_NS 4000
`define I2CBS_T_SETUP_FST_NS 600
`define I2CBS_T_LOW_STD_NS   4700
`define I2CBS_T_LOW_FST_NS   1300
`define I2CBS_T_HIGH_STD_NS  4000
`define I2CBS_T_HIGH_FST_NS  600

// register byte offsets
`define I2CBS_A_SHIFT        8'h00
`define I2CBS_A_CTRL         8'h04
`define I2CBS_A_STAT         8'h08
`define I2CBS_A_OWN          8'h0c
`define I2CBS_A_IST          8'h10
`define I2CBS_A_IMSK         8'h14

// control fields
`define I2CBS_C_START        0
`define I2CBS_C_STOP         1
`define I2CBS_C_WREL         2
`define I2CBS_C_ACKE         3
`define I2CBS_C_FAST         4

// status fields
`define I2CBS_S_ACKD         0
`define I2CBS_S_BUSY         1
`define I2CBS_S_SLV          2
`define I2CBS_S_TRC          3
`define I2CBS_S_MST          4
`define I2CBS_S_WAIT         5

// interrupt status and mask fields
`define I2CBS_I_SENT         0
`define I2CBS_I_MATCH        1
`define I2CBS_I_XFER         2
`define I2CBS_I_STOP         3

// reset values
`define I2CBS_ACKE_RST       1'h1
`define I2CBS_FAST_RST       1'h0
`define I2CBS_OWN_RST        7'h00
`define I2CBS_MASK_RST       4'h0

`endif

// *** verilog/i2cbs_pkg.sv ***
// types of the i2c byte sequencer
package i2cbs_pkg;

    typedef enum logic [2:0] {
        M_IDLE,
        M_HOLD,
        M_WAIT,
        M_BLOW,
        M_BHIGH,
        M_STOPA,
        M_STOPB
    } i2cbs_mstate_t;

    typedef struct packed {
        logic fast;
        logic acke;
    } i2cbs_ctrl_t;

    typedef struct packed {
        logic stop;
        logic xfer;
        logic match;
        logic sent;
    } i2cbs_ev_t;

endpackage : i2cbs_pkg

// *** verilog/i2cbs_top.sv ***
// i2c master and slave byte sequencer with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "i2cbs_params.svh"

// Contract
// - transmit bits leave on the falling clock edge, most significant first
// - receiver shifts the data line in on each rising clock edge
// - status bit 3 shows the transfer direction once addressed
// - start trigger pulls data low, sets master flag, then clock low
// - start hold at least 4.0us standard, 0.6us fast
// - writing address plus direction after start sends the address
// - matching slave acks the address; master samples ack on ninth rise, here only after a write address: a read clears trc_q at the eighth fall
// - ninth fall: master address-sent interrupt; matching slave waits, interrupts
// - non-matching slave gives no ack, no interrupt, no wait
// - address-sent interrupt comes on ack and on no-ack alike
// - master data shifts only once the slave lets the clock rise
// - slave with ack enable acks each byte; master flags it
// - both hold clock low on ninth fall of a byte and interrupt
// - stop trigger: data low, clock released, then data released
// - stop setup at least 4.0us standard, 0.6us fast
// - slave detects the stop condition and interrupts
module i2cbs_top (
    // clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    // register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // interrupt
    output logic            IRQ,
    // bus clock line
    input  wire logic       SCL_I,
    output logic            SCL_O,
    output logic            SCL_OE_N,
    // bus data line
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_N
);

    localparam logic [9:0] HOLD_STD  = 10'(`I2CBS_NS2CYC(`I2CBS_T_HOLD_STD_NS));
    localparam logic [9:0] HOLD_FST  = 10'(`I2CBS_NS2CYC(`I2CBS_T_HOLD_FST_NS));
    localparam logic [9:0] SETUP_STD = 10'(`I2CBS_NS2CYC(`I2CBS_T_SETUP_STD_NS));
    localparam logic [9:0] SETUP_FST = 10'(`I2CBS_NS2CYC(`I2CBS_T_SETUP_FST_NS));
    localparam logic [9:0] LOW_STD   = 10'(`I2CBS_NS2CYC(`I2CBS_T_LOW_STD_NS));
    localparam logic [9:0] LOW_FST   = 10'(`I2CBS_NS2CYC(`I2CBS_T_LOW_FST_NS));
    localparam logic [9:0] HIGH_STD  = 10'(`I2CBS_NS2CYC(`I2CBS_T_HIGH_STD_NS));
    localparam logic [9:0] HIGH_FST  = 10'(`I2CBS_NS2CYC(`I2CBS_T_HIGH_FST_NS));

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    function automatic logic [9:0] pick(input logic f, input logic [9:0] s,
                                        input logic [9:0] q);
        return f ? q : s;
    endfunction : pick

    // synchronisers and edge history
    logic                  scl_m_q, scl_s_q, scl_p_q;
    logic                  sda_m_q, sda_s_q, sda_p_q;
    // registers
    logic            [7:0] sr_q;
    i2cbs_pkg::i2cbs_ctrl_t ctrl_q;
    logic            [6:0] own_q;
    logic            [3:0] ist_q, imsk_q;
    // sequencing state
    i2cbs_pkg::i2cbs_mstate_t mst_q;
    logic            [9:0] cnt_q;
    logic                  m_scl_low_q, m_sda_low_q, own_start_q;
    logic            [3:0] bit_cnt_q;
    logic                  addr_ph_q, trc_q, ackd_q, slv_q, wait_q;
    logic                  sda_drv_q, mstf_q, busy_q;
    // combinational
    logic                  scl_rise, scl_fall, start_det, stop_det;
    logic                  wr_sr, wr_ctrl, start_go, stop_go, rel_master;
    logic                  own_hit;
    logic            [9:0] lim_hold, lim_setup, lim_low, lim_high;
    logic            [7:0] stat;
    i2cbs_pkg::i2cbs_ev_t  ev;

    // first stage feeds only the second
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            scl_m_q <= 1'h1;
            scl_s_q <= 1'h1;
            scl_p_q <= 1'h1;
            sda_m_q <= 1'h1;
            sda_s_q <= 1'h1;
            sda_p_q <= 1'h1;
        end else begin
            scl_m_q <= SCL_I;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= SDA_I;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    assign scl_rise  = scl_s_q & ~scl_p_q;
    assign scl_fall  = ~scl_s_q & scl_p_q;
    assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    assign lim_hold  = pick(ctrl_q.fast, HOLD_STD, HOLD_FST);
    assign lim_setup = pick(ctrl_q.fast, SETUP_STD, SETUP_FST);
    assign lim_low   = pick(ctrl_q.fast, LOW_STD, LOW_FST);
    assign lim_high  = pick(ctrl_q.fast, HIGH_STD, HIGH_FST);

    assign wr_sr     = WR & hit(ADDR, `I2CBS_A_SHIFT);
    assign wr_ctrl   = WR & hit(ADDR, `I2CBS_A_CTRL);
    assign start_go  = wr_ctrl & WDATA[`I2CBS_C_START] & ~busy_q & (mst_q == i2cbs_pkg::M_IDLE);
    assign stop_go   = wr_ctrl & WDATA[`I2CBS_C_STOP];
    // a transmitting master ignores wait release
    assign rel_master = mstf_q & (wr_sr | (wr_ctrl & WDATA[`I2CBS_C_WREL] & ~trc_q));
    assign own_hit   = sr_q[7:1] == own_q;

    always_comb begin
        ev.sent  = scl_fall & (bit_cnt_q == 4'h8) & addr_ph_q & mstf_q;
        ev.match = scl_fall & (bit_cnt_q == 4'h8) & addr_ph_q & slv_q;
        ev.xfer  = scl_fall & (bit_cnt_q == 4'h8) & ~addr_ph_q & (mstf_q | slv_q);
        ev.stop  = stop_det;
    end

    // master clock and start/stop generation
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mst_q       <= i2cbs_pkg::M_IDLE;
            cnt_q       <= 10'h000;
            m_scl_low_q <= 1'h0;
            m_sda_low_q <= 1'h0;
            own_start_q <= 1'h0;
        end else begin
            cnt_q <= cnt_q + 10'h001;
            unique case (mst_q)
                i2cbs_pkg::M_IDLE: begin
                    cnt_q <= 10'h000;
                    if (start_go) begin
                        m_sda_low_q <= 1'h1;
                        own_start_q <= 1'h1;
                    end
                    if (start_det && own_start_q) begin
                        own_start_q <= 1'h0;
                        mst_q       <= i2cbs_pkg::M_HOLD;
                    end
                end
                i2cbs_pkg::M_HOLD: begin
                    if (cnt_q >= lim_hold) begin
                        m_scl_low_q <= 1'h1;
                        mst_q       <= i2cbs_pkg::M_WAIT;
                    end
                end
                i2cbs_pkg::M_WAIT: begin
                    cnt_q       <= 10'h000;
                    // sda let go a cycle after scl went low, never while high
                    m_sda_low_q <= 1'h0;
                    if (!mstf_q) begin
                        m_scl_low_q <= 1'h0;
                        mst_q       <= i2cbs_pkg::M_IDLE;
                    end else if (rel_master) begin
                        mst_q <= i2cbs_pkg::M_BLOW;
                    end else if (stop_go) begin
                        m_sda_low_q <= 1'h1;
                        mst_q       <= i2cbs_pkg::M_STOPA;
                    end
                end
                i2cbs_pkg::M_BLOW: begin
                    if (cnt_q >= lim_low) begin
                        cnt_q       <= 10'h000;
                        m_scl_low_q <= 1'h0;
                        mst_q       <= i2cbs_pkg::M_BHIGH;
                    end
                end
                i2cbs_pkg::M_BHIGH: begin
                    // a waiting slave keeps the line low; count from the real rise
                    if (!scl_s_q) begin
                        cnt_q <= 10'h000;
                    end else if (cnt_q >= lim_high) begin
                        cnt_q       <= 10'h000;
                        m_scl_low_q <= 1'h1;
                        if (bit_cnt_q == 4'h8) begin
                            mst_q <= i2cbs_pkg::M_WAIT;
                        end else begin
                            mst_q <= i2cbs_pkg::M_BLOW;
                        end
                    end
                end
                i2cbs_pkg::M_STOPA: begin
                    if (cnt_q >= lim_low) begin
                        cnt_q       <= 10'h000;
                        m_scl_low_q <= 1'h0;
                        mst_q       <= i2cbs_pkg::M_STOPB;
                    end
                end
                i2cbs_pkg::M_STOPB: begin
                    if (!scl_s_q) begin
                        cnt_q <= 10'h000;
                    end else if (cnt_q >= lim_setup) begin
                        m_sda_low_q <= 1'h0;
                        mst_q       <= i2cbs_pkg::M_IDLE;
                    end
                end
            endcase
        end
    end

    // shared shift path, acknowledge and slave wait
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sr_q      <= 8'h00;
            bit_cnt_q <= 4'h0;
            addr_ph_q <= 1'h0;
            trc_q     <= 1'h0;
            ackd_q    <= 1'h0;
            slv_q     <= 1'h0;
            wait_q    <= 1'h0;
            sda_drv_q <= 1'h0;
            mstf_q    <= 1'h0;
            busy_q    <= 1'h0;
        end else begin
            if (wr_sr) begin
                sr_q <= WDATA;
                if (mstf_q && addr_ph_q) begin
                    trc_q     <= 1'h1;
                    sda_drv_q <= ~WDATA[7];
                end else if (trc_q) begin
                    sda_drv_q <= ~WDATA[7];
                end
                wait_q <= 1'h0;
            end
            if (wr_ctrl && WDATA[`I2CBS_C_WREL] && !trc_q) begin
                wait_q <= 1'h0;
            end
            if (scl_rise) begin
                if (bit_cnt_q < 4'h8) begin
                    sr_q <= {sr_q[6:0], sda_s_q};
                end else if (trc_q) begin
                    ackd_q <= ~sda_s_q;
                end
            end
            if (scl_fall) begin
                if (bit_cnt_q == 4'hf) begin
                    // the fall that closes a start carries no bit
                    bit_cnt_q <= 4'h0;
                end else if (bit_cnt_q < 4'h7) begin
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (trc_q) begin
                        sda_drv_q <= ~sr_q[7];
                    end
                end else if (bit_cnt_q == 4'h7) begin
                    bit_cnt_q <= 4'h8;
                    sda_drv_q <= 1'h0;
                    if (addr_ph_q && mstf_q) begin
                        trc_q <= ~sr_q[0];
                    end else if (addr_ph_q && own_hit) begin
                        sda_drv_q <= 1'h1;
                        slv_q     <= 1'h1;
                        trc_q     <= sr_q[0];
                    end else if (!addr_ph_q && slv_q && !trc_q && ctrl_q.acke) begin
                        sda_drv_q <= 1'h1;
                    end
                end else begin
                    bit_cnt_q <= 4'h0;
                    addr_ph_q <= 1'h0;
                    sda_drv_q <= 1'h0;
                    if (slv_q) begin
                        wait_q <= 1'h1;
                    end
                end
            end
            if (start_det) begin
                bit_cnt_q <= 4'hf;
                addr_ph_q <= 1'h1;
                slv_q     <= 1'h0;
                trc_q     <= 1'h0;
                ackd_q    <= 1'h0;
                wait_q    <= 1'h0;
                sda_drv_q <= 1'h0;
                busy_q    <= 1'h1;
                if (own_start_q) begin
                    mstf_q <= 1'h1;
                end
            end
            if (stop_det) begin
                busy_q    <= 1'h0;
                mstf_q    <= 1'h0;
                slv_q     <= 1'h0;
                trc_q     <= 1'h0;
                wait_q    <= 1'h0;
                sda_drv_q <= 1'h0;
                addr_ph_q <= 1'h0;
            end
        end
    end

    // control, own address and interrupt registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl_q.acke <= `I2CBS_ACKE_RST;
            ctrl_q.fast <= `I2CBS_FAST_RST;
            own_q       <= `I2CBS_OWN_RST;
            imsk_q      <= `I2CBS_MASK_RST;
            ist_q       <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q.acke <= WDATA[`I2CBS_C_ACKE];
                ctrl_q.fast <= WDATA[`I2CBS_C_FAST];
            end
            if (WR && hit(ADDR, `I2CBS_A_OWN)) begin
                own_q <= WDATA[7:1];
            end
            if (WR && hit(ADDR, `I2CBS_A_IMSK)) begin
                imsk_q <= WDATA[3:0];
            end
            // a new event outweighs a clear in the same cycle
            ist_q <= (ist_q & ~((WR && hit(ADDR, `I2CBS_A_IST)) ? WDATA[3:0] : 4'h0)) | ev;
        end
    end

    always_comb begin
        stat                = 8'h00;
        stat[`I2CBS_S_ACKD] = ackd_q;
        stat[`I2CBS_S_BUSY] = busy_q;
        stat[`I2CBS_S_SLV]  = slv_q;
        stat[`I2CBS_S_TRC]  = trc_q;
        stat[`I2CBS_S_MST]  = mstf_q;
        stat[`I2CBS_S_WAIT] = wait_q;
    end

    // read data, interrupt and pin drivers, all registered
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            RDATA    <= 8'h00;
            IRQ      <= 1'h0;
            SCL_O    <= 1'h0;
            SDA_O    <= 1'h0;
            SCL_OE_N <= 1'h1;
            SDA_OE_N <= 1'h1;
        end else begin
            RDATA <= 8'h00;
            if (RD) begin
                unique case (ADDR)
                    `I2CBS_A_SHIFT: RDATA <= sr_q;
                    `I2CBS_A_CTRL: begin
                        RDATA                 <= 8'h00;
                        RDATA[`I2CBS_C_ACKE] <= ctrl_q.acke;
                        RDATA[`I2CBS_C_FAST] <= ctrl_q.fast;
                    end
                    `I2CBS_A_STAT:  RDATA <= stat;
                    `I2CBS_A_OWN:   RDATA <= {own_q, 1'h0};
                    `I2CBS_A_IST:   RDATA <= {4'h0, ist_q};
                    `I2CBS_A_IMSK:  RDATA <= {4'h0, imsk_q};
                    default:        RDATA <= 8'h00;
                endcase
            end
            IRQ      <= |(ist_q & imsk_q);
            // only ever pull low; the wire is high when nobody drives
            SCL_O    <= 1'h0;
            SDA_O    <= 1'h0;
            SCL_OE_N <= ~(m_scl_low_q | wait_q);
            SDA_OE_N <= ~(m_sda_low_q | sda_drv_q);
        end
    end

    // helper run lengths for timing checks
    logic [9:0] hold_run_q, setup_run_q;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            hold_run_q  <= 10'h000;
            setup_run_q <= 10'h000;
        end else begin
            if (mst_q == i2cbs_pkg::M_IDLE) begin
                hold_run_q  <= 10'h000;
                setup_run_q <= 10'h000;
            end
            if (mst_q == i2cbs_pkg::M_HOLD) begin
                hold_run_q <= hold_run_q + 10'h001;
            end
            if (mst_q == i2cbs_pkg::M_STOPB && scl_s_q) begin
                setup_run_q <= setup_run_q + 10'h001;
            end
        end
    end

    chk_start_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(m_scl_low_q) && $past(mst_q) == i2cbs_pkg::M_HOLD |-> hold_run_q >= lim_hold)
        else $error("start hold too short");

    chk_stop_setup: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(m_sda_low_q) && $past(mst_q) == i2cbs_pkg::M_STOPB
        |-> setup_run_q >= lim_setup)
        else $error("stop setup too short");

    chk_master_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
        start_det && own_start_q |=> mstf_q && mst_q == i2cbs_pkg::M_HOLD)
        else $error("own start not taken");

    chk_rise_sample: assert property (@(posedge CLK_SYS) disable iff (RST)
        scl_rise && bit_cnt_q < 4'h8 && !wr_sr |=> sr_q[0] == $past(sda_s_q))
        else $error("bit not sampled on rise");

    chk_fall_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
        scl_fall && trc_q && bit_cnt_q < 4'h7 && !wr_sr && !start_det && !stop_det
        |=> sda_drv_q == !$past(sr_q[7]) ##1 SDA_OE_N == !sda_drv_q)
        else $error("msb not driven on fall");

    chk_ack_sample: assert property (@(posedge CLK_SYS) disable iff (RST)
        scl_rise && bit_cnt_q == 4'h8 && trc_q |=> ackd_q == !$past(sda_s_q))
        else $error("ack not flagged");

    chk_ninth_wait: assert property (@(posedge CLK_SYS) disable iff (RST)
        ev.xfer && slv_q && !stop_det |=> wait_q ##1 !SCL_OE_N)
        else $error("slave did not hold clock");

    chk_no_match: assert property (@(posedge CLK_SYS) disable iff (RST)
        scl_fall && bit_cnt_q == 4'h7 && addr_ph_q && !mstf_q && !own_hit && !start_det
        |=> !sda_drv_q && !slv_q)
        else $error("unmatched slave answered");

    chk_addr_sent: assert property (@(posedge CLK_SYS) disable iff (RST)
        ev.sent |=> ist_q[`I2CBS_I_SENT])
        else $error("address sent not flagged");

    chk_sda_low_clk: assert property (@(posedge CLK_SYS) disable iff (RST)
        $changed(sda_drv_q) && !start_det && !stop_det
        && !(mst_q inside {i2cbs_pkg::M_IDLE, i2cbs_pkg::M_STOPB}) |-> !scl_s_q)
        else $error("data moved with clock high");

endmodule : i2cbs_top
`default_nettype wire

// *** tb/i2cbs_slave_model.sv ***
// behavioural i2c slave on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module i2cbs_slave_model #(
    parameter logic [6:0] ADDR_ME    = 7'h5a,
    parameter int         STRETCH_NS = 3000
) (
    // wire levels
    input  wire logic scl,
    input  wire logic sda,
    // open drain pulls, low while pulling
    output logic      scl_oe_n,
    output logic      sda_oe_n
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    logic       hit;
    int         stop_cnt;

    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
        stop_cnt = 0;
    end

    // stop aborts any byte in progress
    always @(posedge sda) if (scl === 1'b1 && $realtime > 0) begin
        stop_cnt++;
        sda_oe_n = 1'b1;
        disable rx;
    end

    always @(negedge sda) if (scl === 1'b1) begin : rx
        hit = 1'b0;
        forever begin
            repeat (8) begin
                @(posedge scl);
                sh = {sh[6:0], sda};
            end
            @(negedge scl);
            if (!hit)
                hit = (sh[7:1] == ADDR_ME);
            else
                rx_q.push_back(sh);
            #100 sda_oe_n = !hit;
            @(negedge scl);
            #100 sda_oe_n = 1'b1;
            if (hit) begin
                scl_oe_n = 1'b0;
                #(STRETCH_NS) scl_oe_n = 1'b1;
            end
        end
    end
endmodule : i2cbs_slave_model
`default_nettype wire

// *** tb/i2cbs_top_tb.sv ***
// self-checking bench: master write to a behavioural slave
`timescale 1ns/1ps
`default_nettype none
`include "i2cbs_params.svh"
module i2cbs_top_tb;
    logic       clk_sys, rst, wr, rd;
    logic [7:0] addr, wdata, rdata, d;
    logic       irq, scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl_oe_n, m_sda_oe_n;
    // bench pulls stand in for a second master
    logic       b_scl = 1'b1, b_sda = 1'b1;
    wire logic  scl = (scl_oe_n | scl_o) & m_scl_oe_n & b_scl;
    wire logic  sda = (sda_oe_n | sda_o) & m_sda_oe_n & b_sda;
    int         fail_count = 0, cmp_count = 0, edge_hi = 0;
    realtime    t_sdaf = 0, t_sclr = 0, hold = 0, setup = 0;
    logic [7:0] rows [6][2] = '{'{`I2CBS_A_CTRL, 8'h08}, '{`I2CBS_A_STAT, 8'h00},
        '{`I2CBS_A_OWN, 8'h00}, '{`I2CBS_A_IST, 8'h00}, '{`I2CBS_A_IMSK, 8'h00},
        '{8'h20, 8'h00}};

    i2cbs_top u_i2cbs_top (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .SCL_I(scl), .SCL_O(scl_o),
        .SCL_OE_N(scl_oe_n), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n));
    i2cbs_slave_model #(.ADDR_ME(7'h5a), .STRETCH_NS(3000)) u_i2cbs_slave_model (
        .scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // line timing seen on the wires
    always @(sda) if (scl === 1'b1 && $realtime > 0) edge_hi++;
    always @(negedge sda) if (scl === 1'b1) t_sdaf = $realtime;
    always @(negedge scl) if (t_sdaf > 0) begin
        hold = $realtime - t_sdaf;
        t_sdaf = 0;
    end
    always @(posedge scl) t_sclr = $realtime;
    always @(posedge sda) if (scl === 1'b1) setup = $realtime - t_sclr;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wrr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wrr

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys);
        rd <= 1'b1; addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rdr

    task automatic wait_bit(input logic [7:0] a, input logic [7:0] m);
        int i;
        for (i = 0; i < 20000; i++) begin
            rdr(a);
            if ((d & m) === m) break;
        end
        chk(d & m, m, "wait bit");
    endtask : wait_bit

    task automatic send(input logic [7:0] v, input logic [7:0] ev);
        wrr(`I2CBS_A_SHIFT, v);
        wait_bit(`I2CBS_A_IST, ev);
    endtask : send

    task automatic open_bus;
        int i;
        wrr(`I2CBS_A_CTRL, 8'h19);
        wait_bit(`I2CBS_A_STAT, 8'h10);
        for (i = 0; i < 2000 && scl !== 1'b0; i++) @(posedge clk_sys);
        chk(8'(hold >= 600.0), 8'h01, "start hold");
    endtask : open_bus

    // one bit as a second master; waits out a held clock
    task automatic bm_bit(input logic b, output logic s);
        b_sda <= b;
        repeat (200) @(posedge clk_sys);
        b_scl <= 1'b1;
        @(posedge clk_sys);
        while (scl !== 1'b1) @(posedge clk_sys);
        s = sda;
        repeat (200) @(posedge clk_sys);
        b_scl <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask : bm_bit

    task automatic bm_byte(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bm_bit(v[i], s);
        bm_bit(1'b1, s);
        chk(8'(s), 8'h00, "slave ack");
    endtask : bm_byte

    task automatic print_verdict;
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    initial begin
        #400_000;
        fail_count++;
        print_verdict();
    end

    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            rdr(rows[i][0]);
            chk(d, rows[i][1], "reset value");
        end
        wrr(`I2CBS_A_CTRL, 8'h18);
        wrr(`I2CBS_A_IMSK, 8'h05);
        open_bus();
        send({7'h5a, 1'b0}, 8'h01);
        chk(8'(irq), 8'h01, "irq sent");
        rdr(`I2CBS_A_STAT);
        chk(d & 8'h1b, 8'h1b, "status after address");
        wrr(`I2CBS_A_IST, 8'h01);
        rdr(`I2CBS_A_IST);
        chk(d, 8'h00, "ist cleared");
        chk(8'(irq), 8'h00, "irq cleared");
        send(8'ha5, 8'h04);
        wrr(`I2CBS_A_IST, 8'h04);
        wrr(`I2CBS_A_CTRL, 8'h1c);
        repeat (2000) @(posedge clk_sys);
        chk(8'(u_i2cbs_slave_model.rx_q.size()), 8'h01, "wait release refused");
        send(8'h3c, 8'h04);
        wrr(`I2CBS_A_IST, 8'h04);
        wrr(`I2CBS_A_CTRL, 8'h1a);
        for (int i = 0; i < 2000 && u_i2cbs_slave_model.stop_cnt < 1; i++) @(posedge clk_sys);
        chk(8'(u_i2cbs_slave_model.stop_cnt), 8'h01, "stop seen");
        chk(8'(setup >= 600.0), 8'h01, "stop setup");
        chk(u_i2cbs_slave_model.rx_q[0], 8'ha5, "byte 0");
        chk(u_i2cbs_slave_model.rx_q[1], 8'h3c, "byte 1");
        // unknown address: no ack, event still raised, masked from irq
        wrr(`I2CBS_A_IMSK, 8'h04);
        repeat (500) @(posedge clk_sys);
        open_bus();
        send({7'h5b, 1'b0}, 8'h01);
        chk(8'(irq), 8'h00, "irq masked");
        rdr(`I2CBS_A_STAT);
        chk(d & 8'h01, 8'h00, "no ack");
        wrr(`I2CBS_A_CTRL, 8'h1a);
        for (int i = 0; i < 2000 && u_i2cbs_slave_model.stop_cnt < 2; i++) @(posedge clk_sys);
        chk(8'(edge_hi), 8'h04, "data edges while clock high");
        // bench as master, block as addressed slave receiving one byte
        wrr(`I2CBS_A_OWN, 8'h66);
        wrr(`I2CBS_A_IST, 8'h0f);
        b_sda <= 1'b0;
        repeat (100) @(posedge clk_sys);
        b_scl <= 1'b0;
        repeat (8) @(posedge clk_sys);
        bm_byte(8'h66);
        rdr(`I2CBS_A_IST);
        chk(d, 8'h02, "address match");
        chk(8'(scl_oe_n), 8'h00, "slave holds clock");
        rdr(`I2CBS_A_STAT);
        chk(d, 8'h26, "slave status");
        wrr(`I2CBS_A_CTRL, 8'h1c);
        bm_byte(8'h96);
        rdr(`I2CBS_A_SHIFT);
        chk(d, 8'h96, "slave byte");
        rdr(`I2CBS_A_IST);
        chk(d, 8'h06, "slave transfer end");
        wrr(`I2CBS_A_SHIFT, 8'hff);
        b_sda <= 1'b0;
        repeat (200) @(posedge clk_sys);
        b_scl <= 1'b1;
        repeat (300) @(posedge clk_sys);
        b_sda <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rdr(`I2CBS_A_IST);
        chk(d & 8'h08, 8'h08, "slave stop");
        print_verdict();
    end
endmodule : i2cbs_top_tb
`default_nettype wire
